// ---- hdl/pld_powerdown_reset_hold.sv ----
// power-up clear, pin-controlled sleep, preload, security and keepers of a small logic device
//
// Summary of operation
// - power-up clears every macrocell register low
// - registered outputs read high after clear
// - without option, sleep pin is logic input
// - sleep freezes registers, logic and outputs
// - high-impedance outputs stay so while asleep
// - asleep, sequencer ignores all inputs but sleep pin and sleep option
// - pin keepers stay active while asleep
// - outputs valid soon after wake
// - test mode forces each register high/low
// - security fuse blocks readback and preload
// - user signature readable at all times
// - undriven pins hold their last level
`timescale 1ns/100ps
`include "pld_consts.svh"
module pld_powerdown_reset_hold #(
	parameter logic [63:0] USER_SIGNATURE = `USER_SIG_DEFAULT // arbitrary value
) (
	// clock and power-on reset
	input  wire logic                  clk_sys,
	input  wire logic                  reset,
	// board pins
	input  wire logic                  dev_clk_pin,
	input  wire logic                  oe_n_pin,
	input  wire logic                  sleep_request_pin,
	input  wire logic [7:0]            logic_in,
	// bidirectional pins
	input  wire logic [7:0]            io_i,
	input  wire logic [7:0]            io_ext_drive,
	output logic [7:0]                 io_o,
	output logic [7:0]                 io_oe,
	// configuration
	input  wire logic                  sleep_option,
	input  wire logic                  fuse_state_in,
	input  wire logic                  fuse_program,
	// test access
	input  wire logic                  test_mode,
	input  wire logic                  preload_req,
	input  wire logic [7:0]            preload_mask,
	input  wire logic [7:0]            preload_value,
	input  wire logic                  readback_req,
	input  wire logic                  sig_req,
	input  wire logic [`SIG_IDX_W-1:0] sig_index,
	// status and answers
	output logic                       powerup_busy,
	output logic                       sleeping,
	output logic                       secured,
	output logic                       aux_input,
	output logic [7:0]                 readback_data,
	output logic                       readback_valid,
	output logic                       request_refused,
	output logic [7:0]                 sig_byte,
	output logic                       sig_valid
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	pld_pkg::seq_state_e state_r, state_nxt;     // sequencer state
	logic [`CNT_W-1:0]   cnt_r, cnt_nxt;         // power-up and wake timer
	pld_pkg::mc_word_t   mc_r, mc_nxt;           // macrocell registers
	logic                clk_prev_r, clk_prev_nxt; // last device clock level
	logic                oe_n_r, oe_n_nxt;       // accepted output enable
	logic [7:0]          io_o_r, io_o_nxt;       // pin output values
	logic [7:0]          io_oe_r, io_oe_nxt;     // pin drive enables
	logic                fuse_r, fuse_nxt;       // security fuse
	logic                aux_r, aux_nxt;         // sleep pin as logic input
	logic [7:0]          rb_data_r, rb_data_nxt; // readback word
	logic                rb_valid_r, rb_valid_nxt;
	logic                refused_r, refused_nxt;
	logic [7:0]          sig_r, sig_nxt;         // signature byte
	logic                sig_valid_r, sig_valid_nxt;
	logic                clk_rise;               // device clock edge
	logic                sleep_req;              // sleep asked and enabled

	keeper_if kp ();

	// ------------------------------------------------------------
	// pin keeper
	// ------------------------------------------------------------
	pin_keeper u_keeper (
		.clk_sys (clk_sys),
		.reset   (reset),
		.kp      (kp.keeper)
	);

	assign kp.pin_in    = io_i;
	assign kp.ext_drive = io_ext_drive;
	assign kp.own_oe    = io_oe_r;
	assign kp.own_out   = io_o_r;

	// sleep exists only when the option is configured
	assign sleep_req = sleep_option & sleep_request_pin;
	assign clk_rise  = dev_clk_pin & ~clk_prev_r;

	// ------------------------------------------------------------
	// sequencer and macrocells
	// ------------------------------------------------------------
	always_comb begin
		state_nxt    = state_r;
		cnt_nxt      = cnt_r;
		mc_nxt       = mc_r;
		clk_prev_nxt = clk_prev_r;
		oe_n_nxt     = oe_n_r;
		io_o_nxt     = io_o_r;
		io_oe_nxt    = io_oe_r;
		aux_nxt      = aux_r;
		case (state_r)
			pld_pkg::ST_POWERUP: begin
				// clock edges are not taken while the clear interval runs
				clk_prev_nxt = dev_clk_pin;
				if (cnt_r == `CNT_W'(`POWERUP_CLEAR_CYC - 1)) begin
					state_nxt = pld_pkg::ST_RUN;
					cnt_nxt   = '0;
				end else begin
					cnt_nxt = cnt_r + `CNT_W'(1);
				end
			end
			pld_pkg::ST_SLEEP: begin
				// everything holds; only the sleep pin and the sleep option are looked at
				if (!sleep_req) begin
					state_nxt = pld_pkg::ST_WAKE;
					cnt_nxt   = '0;
				end
			end
			pld_pkg::ST_RUN, pld_pkg::ST_WAKE: begin
				clk_prev_nxt = dev_clk_pin;
				// without the option the pin feeds the array
				aux_nxt = sleep_option ? 1'b0 : sleep_request_pin;
				if (sleep_req) begin
					// freeze at once: a device clock edge in this cycle is not taken; prior state stays as is
					state_nxt = pld_pkg::ST_SLEEP;
				end else if (state_r == pld_pkg::ST_WAKE) begin
					// clock and enable ignored until the wake delay ends
					if (cnt_r == `CNT_W'(`WAKE_CLK_ACCEPT_CYC - 1)) begin
						state_nxt = pld_pkg::ST_RUN;
					end else begin
						cnt_nxt = cnt_r + `CNT_W'(1);
					end
				end else begin
					oe_n_nxt = oe_n_pin;
					if (test_mode && preload_req && !fuse_nxt) begin
						// per-bit force high or low, barred in the very cycle the fuse is blown
						mc_nxt = (mc_r & ~preload_mask) | (preload_value & preload_mask);
					end else if (clk_rise) begin
						mc_nxt = logic_in ^ {8{aux_nxt}};
					end
				end
			end
			default: begin
				state_nxt = pld_pkg::ST_POWERUP;
			end
		endcase
		// enabled outputs are inverted registers, released ones follow the keeper; refreshed only when awake
		if (state_r != pld_pkg::ST_SLEEP) begin
			io_oe_nxt = {8{~oe_n_nxt}};
			io_o_nxt  = oe_n_nxt ? kp.level : ~mc_nxt;
		end
	end

	// ------------------------------------------------------------
	// security and test answers
	// ------------------------------------------------------------
	always_comb begin
		// fuse acts on the same cycle it is programmed
		fuse_nxt      = fuse_r | fuse_state_in | fuse_program;
		rb_data_nxt   = rb_data_r;
		rb_valid_nxt  = 1'b0;
		refused_nxt   = 1'b0;
		sig_nxt       = sig_r;
		sig_valid_nxt = 1'b0;
		if (readback_req && test_mode) begin
			if (fuse_nxt) begin
				rb_data_nxt = 8'h00;
				refused_nxt = 1'b1; // verify inhibited once secured
			end else begin
				rb_data_nxt  = mc_r;
				rb_valid_nxt = 1'b1;
			end
		end else if (preload_req && test_mode && fuse_nxt) begin
			refused_nxt = 1'b1; // preload inhibited
		end
		if (sig_req) begin
			// signature ignores fuse and sleep
			sig_nxt       = USER_SIGNATURE[{sig_index, 3'b000} +: 8];
			sig_valid_nxt = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_r     <= pld_pkg::ST_POWERUP;
			cnt_r       <= '0;
			mc_r        <= `MC_RESET;  // power-up clear low
			clk_prev_r  <= 1'b0;
			oe_n_r      <= 1'b1;
			io_o_r      <= ~`MC_RESET; // inverted clear reads high
			io_oe_r     <= 8'h00;
			fuse_r      <= 1'b0;
			aux_r       <= 1'b0;
			rb_data_r   <= 8'h00;
			rb_valid_r  <= 1'b0;
			refused_r   <= 1'b0;
			sig_r       <= 8'h00;
			sig_valid_r <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			cnt_r       <= cnt_nxt;
			mc_r        <= mc_nxt;
			clk_prev_r  <= clk_prev_nxt;
			oe_n_r      <= oe_n_nxt;
			io_o_r      <= io_o_nxt;
			io_oe_r     <= io_oe_nxt;
			fuse_r      <= fuse_nxt;
			aux_r       <= aux_nxt;
			rb_data_r   <= rb_data_nxt;
			rb_valid_r  <= rb_valid_nxt;
			refused_r   <= refused_nxt;
			sig_r       <= sig_nxt;
			sig_valid_r <= sig_valid_nxt;
		end
	end

	// status flags from their own flops so every output is registered
	logic busy_r, sleeping_r;
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			busy_r     <= 1'b1;
			sleeping_r <= 1'b0;
		end else begin
			busy_r     <= (state_nxt == pld_pkg::ST_POWERUP);
			sleeping_r <= (state_nxt == pld_pkg::ST_SLEEP);
		end
	end

	assign io_o            = io_o_r;
	assign io_oe           = io_oe_r;
	assign powerup_busy    = busy_r;
	assign sleeping        = sleeping_r;
	assign secured         = fuse_r;
	assign aux_input       = aux_r;
	assign readback_data   = rb_data_r;
	assign readback_valid  = rb_valid_r;
	assign request_refused = refused_r;
	assign sig_byte        = sig_r;
	assign sig_valid       = sig_valid_r;
endmodule

// ---- hdl/pld_consts.svh ----
// timing counts, widths and reset values of the power-down and reset hold block
`ifndef PLD_CONSTS_SVH
`define PLD_CONSTS_SVH

// ------------------------------------------------------------
// widths
// ------------------------------------------------------------
`define MC_COUNT            8
`define SIG_BYTES           8
`define SIG_IDX_W           3

// ------------------------------------------------------------
// clock and times, all in picoseconds
// ------------------------------------------------------------
`define CLK_PERIOD_PS       4000
`define POWERUP_CLEAR_PS    1000000
`define WAKE_CLK_ACCEPT_PS  15000
`define WAKE_OUT_VALID_PS   20000
`define INPUT_VALID_PS      5000

// longest times round down, never below one cycle
`define POWERUP_CLEAR_CYC   (((`POWERUP_CLEAR_PS / `CLK_PERIOD_PS) < 1) ? 1 : (`POWERUP_CLEAR_PS / `CLK_PERIOD_PS))
`define WAKE_CLK_ACCEPT_CYC (((`WAKE_CLK_ACCEPT_PS / `CLK_PERIOD_PS) < 1) ? 1 : (`WAKE_CLK_ACCEPT_PS / `CLK_PERIOD_PS))
`define CNT_W               8

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define MC_RESET            8'h00
`define USER_SIG_DEFAULT    64'h0123_4567_89ab_cdef

`endif

// ---- hdl/pld_pkg.sv ----
// types shared by the power-down and reset hold block
package pld_pkg;
	// device sequencing states
	typedef enum logic [1:0] {
		ST_POWERUP,
		ST_RUN,
		ST_SLEEP,
		ST_WAKE
	} seq_state_e;

	// one lane of macrocell data
	typedef logic [7:0] mc_word_t;
endpackage

// ---- hdl/keeper_if.sv ----
// carrier between the sequencer and the pin keeper
`timescale 1ns/100ps
interface keeper_if;
	logic [7:0] pin_in;      // sampled pin level
	logic [7:0] ext_drive;   // board reports a strong driver per pin
	logic [7:0] own_oe;      // device output buffer enabled
	logic [7:0] own_out;     // device output buffer value
	logic [7:0] level;       // resolved pin level, held when nobody drives

	modport core   (output pin_in, output ext_drive, output own_oe, output own_out, input level);
	modport keeper (input pin_in, input ext_drive, input own_oe, input own_out, output level);
endinterface

// ---- hdl/pin_keeper.sv ----
// weak hold of each pin's most recent level
`timescale 1ns/100ps
module pin_keeper (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic reset,
	// pin side
	keeper_if.keeper  kp
);
	logic [7:0] level_r;    // held level per pin
	logic [7:0] level_nxt;  // next held level

	// ------------------------------------------------------------
	// next level: own buffer wins, then board, else keep
	// ------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (kp.own_oe[i]) begin
				level_nxt[i] = kp.own_out[i];
			end else if (kp.ext_drive[i]) begin
				level_nxt[i] = kp.pin_in[i];
			end else begin
				level_nxt[i] = level_r[i]; // undriven pin keeps last level
			end
		end
	end

	// keepers have no enable, so they stay active in sleep too
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			level_r <= 8'h00;
		end else begin
			level_r <= level_nxt;
		end
	end

	assign kp.level = level_r;
endmodule

// ---- testbench/pld_sva.sv ----
// assertions on the ports of the power-down and reset hold block
`timescale 1ns/100ps
module pld_sva #(
	parameter logic [63:0] USER_SIGNATURE = 64'h0
) (
	// clock and reset
	input wire logic       clk_sys,
	input wire logic       reset,
	// pins and requests
	input wire logic       sleep_request_pin,
	input wire logic       sleep_option,
	input wire logic       fuse_program,
	input wire logic       fuse_state_in,
	input wire logic       test_mode,
	input wire logic       preload_req,
	input wire logic       readback_req,
	input wire logic       sig_req,
	input wire logic [2:0] sig_index,
	// answers
	input wire logic       powerup_busy,
	input wire logic       sleeping,
	input wire logic       secured,
	input wire logic [7:0] io_o,
	input wire logic [7:0] io_oe,
	input wire logic       readback_valid,
	input wire logic       request_refused,
	input wire logic [7:0] sig_byte,
	input wire logic       sig_valid
);
	logic [7:0] cnt_r;   // edges since reset release, saturates
	logic [7:0] cnt_nxt; // next count
	// saturate so the count never wraps back into the clear window
	always_comb begin
		cnt_nxt = (cnt_r == 8'hff) ? cnt_r : cnt_r + 8'h01;
	end
	// count register
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			cnt_r <= 8'h00;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	chk_clear_len: assert property (powerup_busy == (cnt_r < 8'hfa))
		else $error("clear interval length wrong");
	chk_sleep_entry: assert property (sleep_option && sleep_request_pin && !powerup_busy |=> sleeping)
		else $error("sleep not entered");
	chk_no_option: assert property (!sleep_option |-> !sleeping)
		else $error("sleep without option");
	chk_frozen_pins: assert property (sleeping |=> $stable(io_o) && $stable(io_oe))
		else $error("outputs moved while asleep");
	chk_wake_hold: assert property ($fell(sleeping) |-> $stable(io_o) [*3])
		else $error("outputs moved during wake");
	chk_sig_answer: assert property (sig_req |=> sig_valid && sig_byte == USER_SIGNATURE[$past(sig_index)*8 +: 8])
		else $error("signature byte wrong");
	chk_preload_refuse: assert property (secured && test_mode && preload_req && !sleeping |=> request_refused)
		else $error("preload not refused");
	chk_readback_ok: assert property (test_mode && readback_req && !secured && !fuse_program && !fuse_state_in
		|=> readback_valid)
		else $error("readback not answered");
	chk_readback_lock: assert property (test_mode && readback_req && (secured || fuse_program || fuse_state_in)
		|=> request_refused && !readback_valid)
		else $error("readback not refused");
	// main scenarios reached
	cov_sleep: cover property ($rose(sleeping));
	cov_wake: cover property ($fell(sleeping));
	cov_refuse: cover property (request_refused);
endmodule
bind pld_powerdown_reset_hold pld_sva #(.USER_SIGNATURE(USER_SIGNATURE)) i_pld_sva (.*);

// ---- testbench/board_pins.sv ----
// board side of the two-way pins: a strong driver or a released line
`timescale 1ns/100ps
module board_pins (
	// clock
	input wire logic       clk_sys,
	// board driver
	input wire logic       ext_en,
	input wire logic [7:0] ext_val,
	// device buffer
	input wire logic [7:0] io_o,
	input wire logic [7:0] io_oe,
	// resolved pin
	output logic     [7:0] io_i,
	output logic     [7:0] io_ext_drive
);
	logic [7:0] last_r; // last level the board drove
	// nothing pulls a released line, so it shows the opposite of the last drive
	always_ff @(posedge clk_sys) begin
		if (ext_en) begin
			last_r <= ext_val;
		end
	end
	assign io_ext_drive = {8{ext_en}};
	assign io_i = ext_en ? ext_val : (io_o & io_oe) | (~last_r & ~io_oe);
endmodule

// ---- testbench/tb.sv ----
// self-checking bench of the power-down and reset hold block
`timescale 1ns/100ps
module tb;
	localparam logic [63:0] SIG = 64'hfeed_0bad_1357_2468; // arbitrary signature
	logic clk_sys = 0, reset = 1, dev_clk_pin = 0, oe_n_pin = 1, sleep_request_pin = 0;
	logic sleep_option = 0, fuse_state_in = 0, fuse_program = 0, test_mode = 0, ext_en = 0;
	logic preload_req = 0, readback_req = 0, sig_req = 0;
	logic [7:0] logic_in = 0, preload_mask = 0, preload_value = 0, ext_val = 0;
	logic [2:0] sig_index = 0;
	logic [7:0] io_i, io_ext_drive, io_o, io_oe, readback_data, sig_byte;
	logic powerup_busy, sleeping, secured, aux_input, readback_valid, request_refused, sig_valid;
	int fails = 0, num_checks = 0;
	always #2 clk_sys = ~clk_sys;
	pld_powerdown_reset_hold #(.USER_SIGNATURE(SIG)) i_pld_powerdown_reset_hold (.*);
	board_pins i_board_pins (.*);
	// inputs move on falling edges only
	task cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task chk(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// one device clock pulse with data held around it
	task dpulse(input logic [7:0] d);
		logic_in = d;
		cyc(1);
		dev_clk_pin = 1;
		cyc(1);
		dev_clk_pin = 0;
		cyc(1);
	endtask
	task conclude;
		$display("checks=%0d fails=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task t_powerup;
		int n;
		n = 0;
		while (powerup_busy === 1'b1 && n < 300) begin // device clock held still meanwhile
			cyc(1);
			n++;
		end
		chk(n[7:0], 8'hfa);
		if (n == 300) conclude;
		oe_n_pin = 0;
		cyc(2); // board meets setup before first device clock
		chk(io_oe, 8'hff);
		chk(io_o, 8'hff);
		$display("powerup done");
	endtask
	task t_keeper;
		oe_n_pin = 1;
		ext_en = 1;
		ext_val = 8'hc3;
		cyc(3);
		ext_en = 0;
		cyc(4);
		chk(io_o, 8'hc3);
		$display("keeper done");
	endtask
	task t_noopt;
		oe_n_pin = 0;
		sleep_request_pin = 1;
		dpulse(8'h0f);
		chk({7'h0, sleeping}, 8'h00);
		chk(io_o, 8'h0f);
		chk({7'h0, aux_input}, 8'h01);
		sleep_request_pin = 0;
		$display("no option done");
	endtask
	task t_sleep;
		sleep_option = 1;
		dpulse(8'h96);
		cyc(2); // inputs valid well before the sleep pin
		sleep_request_pin = 1;
		cyc(2);
		chk({7'h0, sleeping}, 8'h01);
		sig_req = 1;
		sig_index = 3'h5;
		cyc(1);
		sig_req = 0;
		chk({7'h0, sig_valid}, 8'h01);
		chk(sig_byte, SIG[47:40]);
		dpulse(8'h11);
		oe_n_pin = 1;
		cyc(2);
		chk(io_o, 8'h69);
		chk(io_oe, 8'hff);
		oe_n_pin = 0;
		sleep_request_pin = 0;
		dpulse(8'h22);
		chk(io_o, 8'h69);
		cyc(3);
		dpulse(8'h44);
		chk(io_o, 8'hbb);
		$display("sleep done");
	endtask
	task t_hiz;
		oe_n_pin = 1;
		cyc(2);
		chk(io_oe, 8'h00);
		sleep_request_pin = 1;
		cyc(2);
		oe_n_pin = 0;
		cyc(3);
		chk(io_oe, 8'h00);
		sleep_request_pin = 0;
		cyc(6);
		chk(io_oe, 8'hff);
		$display("hiz done");
	endtask
	task t_preload(input logic [7:0] m, v, e);
		test_mode = 1;
		preload_mask = m;
		preload_value = v;
		preload_req = 1;
		cyc(1);
		preload_req = 0;
		cyc(1);
		chk(io_o, ~e);
		readback_req = 1;
		cyc(1);
		readback_req = 0;
		chk({7'h0, readback_valid}, 8'h01);
		chk(readback_data, e);
		$display("preload done");
	endtask
	task t_secure;
		fuse_program = 1; // fuse goes last
		cyc(1);
		fuse_program = 0;
		cyc(1);
		chk({7'h0, secured}, 8'h01);
		preload_req = 1;
		cyc(1);
		preload_req = 0;
		chk({7'h0, request_refused}, 8'h01);
		cyc(1);
		chk(io_o, 8'hfa);
		readback_req = 1;
		cyc(1);
		readback_req = 0;
		chk({6'h0, request_refused, readback_valid}, 8'h02);
		sig_req = 1;
		for (int i = 0; i < 8; i++) begin
			sig_index = i[2:0];
			cyc(1);
			chk(sig_byte, SIG[i*8 +: 8]);
			chk({7'h0, sig_valid}, 8'h01);
		end
		sig_req = 0;
		$display("secure done");
	endtask
	initial begin
		cyc(8);
		reset = 0;
		t_powerup;
		t_keeper;
		t_noopt;
		t_sleep;
		t_hiz;
		dpulse(8'h3c);
		t_preload(8'h0f, 8'ha5, 8'h35);
		t_preload(8'hf0, 8'h0f, 8'h05);
		t_secure;
		conclude;
	end
endmodule
